/* File: design/apc_pkg.sv */
// shared constants and types for the audio port format and clock check block
package apc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // register offsets on the documented register port
  localparam logic [7:0] ADDR_CLOCK_CHECK_CONTROL = 8'h25;
  localparam logic [7:0] ADDR_AUDIO_FORMAT_LENGTH = 8'h28;
  localparam logic [7:0] ADDR_AUDIO_DATA_OFFSET = 8'h29;
  localparam logic [7:0] ADDR_CHANNEL_PATH_SELECT = 8'h2a;
  // reset values
  localparam logic [7:0] RST_CLOCK_CHECK_CONTROL = 8'h00;
  localparam logic [7:0] RST_AUDIO_FORMAT_LENGTH = 8'h02;
  localparam logic [7:0] RST_AUDIO_DATA_OFFSET = 8'h00;
  localparam logic [7:0] RST_CHANNEL_PATH_SELECT = 8'h11;
  // writable bit masks, reserved bits read as zero
  localparam logic [7:0] MASK_CLOCK_CHECK_CONTROL = 8'h7f;
  localparam logic [7:0] MASK_AUDIO_FORMAT_LENGTH = 8'h33;
  localparam logic [7:0] MASK_CHANNEL_PATH_SELECT = 8'h33;
  // clock_check_control field positions
  localparam int unsigned BIT_IGNORE_RATE = 6;
  localparam int unsigned BIT_IGNORE_BITCLK = 5;
  localparam int unsigned BIT_IGNORE_MCLK_RATIO = 4;
  localparam int unsigned BIT_IGNORE_MCLK_HALT = 3;
  localparam int unsigned BIT_IGNORE_MISSING = 2;
  localparam int unsigned BIT_AUTOSET_DISABLE = 1;
  localparam int unsigned BIT_IGNORE_PLL = 0;
  // audio_format_length and channel_path_select field positions
  localparam int unsigned POS_FORMAT = 4;
  localparam int unsigned POS_LENGTH = 0;
  localparam int unsigned POS_LEFT_PATH = 4;
  localparam int unsigned POS_RIGHT_PATH = 0;
  // bit clock per frame limits
  localparam logic [11:0] BITCLK_RATIO_MIN = 12'h020;
  localparam logic [11:0] BITCLK_RATIO_MAX = 12'h100;
  // frame period limits: 192 kHz down to 8 kHz
  localparam int unsigned RATE_MIN_PERIOD_NS = 5208;
  localparam int unsigned RATE_MAX_PERIOD_NS = 125000;
  localparam logic [15:0] RATE_MIN_CYC = 16'((RATE_MIN_PERIOD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RATE_MAX_CYC = 16'((RATE_MAX_PERIOD_NS * CLK_MHZ) / 1000);
  // master clock halt: no rising edge for this long
  localparam int unsigned HALT_TIME_NS = 1000;
  localparam logic [15:0] HALT_CYC = 16'((HALT_TIME_NS * CLK_MHZ) / 1000);
  // accepted master clock ratios and tolerance
  localparam int unsigned MCLK_RATIO_COUNT = 8;
  localparam logic [11:0] MCLK_RATIO_TOL = 12'h002;
  localparam logic [11:0] MCLK_RATIOS [MCLK_RATIO_COUNT] = '{
    12'h080, 12'h0c0, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h480};
  // missing clock period step: one second
  localparam int unsigned MISSING_STEP_S = 1;
  localparam int unsigned MISSING_STEP_CYC = MISSING_STEP_S * CLK_MHZ * 1000000;

  typedef enum logic [1:0] {
    APC_FMT_I2S = 2'h0,
    APC_FMT_DSP = 2'h1,
    APC_FMT_RIGHT_JUSTIFIED = 2'h2,
    APC_FMT_LEFT_JUSTIFIED = 2'h3
  } apc_format_t;

  typedef struct packed {
    logic rate_fail;
    logic bitclk_fail;
    logic mclk_ratio_fail;
    logic mclk_halt;
    logic pll_unlock;
  } apc_check_t;

  typedef struct packed {
    logic [6:0] charge_pump_div;
    logic [6:0] osr_div;
    logic [2:0] speed_mode;
  } apc_divider_t;
endpackage

/* File: design/apc_frame_counter.sv */
// counts event pulses over one frame period, saturating
`timescale 1ns/1ps
module apc_frame_counter
  import apc_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic frame_rise,
  input wire logic event_rise,
  output logic [CNT_W-1:0] count,
  output logic done
);
  initial begin
    if (CNT_W < 2) begin
      $error("apc_frame_counter: CNT_W too small");
    end
  end

  logic [CNT_W-1:0] acc;
  wire logic acc_full = &acc;
  wire logic [CNT_W-1:0] acc_inc = acc + CNT_W'(1);
  wire logic [CNT_W-1:0] next_acc = frame_rise ? CNT_W'(event_rise)
                                    : ((event_rise && !acc_full) ? acc_inc : acc);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc <= '0;
      count <= '0;
      done <= 1'b0;
    end else begin
      acc <= next_acc;
      done <= frame_rise;
      if (frame_rise) begin
        count <= acc;
      end
    end
  end
endmodule

/* File: design/apc_clock_check.sv */
// audio port format registers and clock checks
`timescale 1ns/1ps
// How it works
// - rate failure raises clock error unless ignored
// - bit clock must be 32..256 per frame
// - bit clock ratio error gated by ignore bit
// - master clock ratio checked, gated by ignore
// - master clock halt raises error unless ignored
// - both clocks low means missing, powers down
// - autoset unless disable bit set, then manual
// - pll unlock raises error unless ignored
// - pll lock flag always shows true state
// - two-bit format field selects framing mode
// - word length 16/20/24/32, resets to 24
// - eight-bit offset delays sample in bit clocks
// - autoset ignores manual dividers and speed
// - missing period selectable one to eight seconds
module apc_clock_check
  import apc_pkg::*;
#(
  parameter int unsigned MISSING_STEP_CYCLES = MISSING_STEP_CYC,
  parameter int unsigned MCLK_CNT_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic mclk_pin,
  input wire logic bitclk_pin,
  input wire logic frameclk_pin,
  input wire logic pll_locked,
  input wire logic [2:0] missing_clock_period,
  input wire apc_divider_t manual_divider,
  input wire apc_divider_t auto_divider,
  output apc_divider_t active_divider,
  output logic divider_autoset_active,
  output logic clock_error,
  output logic converter_powerdown,
  output logic pll_lock_flag,
  output apc_check_t check_status,
  output apc_format_t frame_format_select,
  output logic [5:0] sample_bits,
  output logic [7:0] sample_bit_offset,
  output logic [1:0] left_path_select,
  output logic [1:0] right_path_select
);
  initial begin
    if (MISSING_STEP_CYCLES < 1 || MISSING_STEP_CYCLES > 32'h1000_0000) begin
      $error("apc_clock_check: MISSING_STEP_CYCLES out of range");
    end
    if (MCLK_CNT_W < 12) begin
      $error("apc_clock_check: MCLK_CNT_W too small for ratios");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] clock_check_control;
  logic [7:0] audio_format_length;
  logic [7:0] audio_data_offset;
  logic [7:0] channel_path_select;

  wire logic wr_ctrl = reg_write && (reg_addr == ADDR_CLOCK_CHECK_CONTROL);
  wire logic wr_fmt = reg_write && (reg_addr == ADDR_AUDIO_FORMAT_LENGTH);
  wire logic wr_ofs = reg_write && (reg_addr == ADDR_AUDIO_DATA_OFFSET);
  wire logic wr_path = reg_write && (reg_addr == ADDR_CHANNEL_PATH_SELECT);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      clock_check_control <= RST_CLOCK_CHECK_CONTROL;
      audio_format_length <= RST_AUDIO_FORMAT_LENGTH;
      audio_data_offset <= RST_AUDIO_DATA_OFFSET;
      channel_path_select <= RST_CHANNEL_PATH_SELECT;
    end else begin
      if (wr_ctrl) clock_check_control <= reg_wdata & MASK_CLOCK_CHECK_CONTROL;
      if (wr_fmt) audio_format_length <= reg_wdata & MASK_AUDIO_FORMAT_LENGTH;
      if (wr_ofs) audio_data_offset <= reg_wdata;
      if (wr_path) channel_path_select <= reg_wdata & MASK_CHANNEL_PATH_SELECT;
    end
  end

  // unmapped offsets read as zero
  assign reg_rdata = (reg_addr == ADDR_CLOCK_CHECK_CONTROL) ? clock_check_control
                   : (reg_addr == ADDR_AUDIO_FORMAT_LENGTH) ? audio_format_length
                   : (reg_addr == ADDR_AUDIO_DATA_OFFSET) ? audio_data_offset
                   : (reg_addr == ADDR_CHANNEL_PATH_SELECT) ? channel_path_select
                   : 8'h00;

  wire logic ignore_rate_check = clock_check_control[BIT_IGNORE_RATE];
  wire logic ignore_bitclk_ratio_check = clock_check_control[BIT_IGNORE_BITCLK];
  wire logic ignore_masterclk_ratio_check = clock_check_control[BIT_IGNORE_MCLK_RATIO];
  wire logic ignore_masterclk_halt_check = clock_check_control[BIT_IGNORE_MCLK_HALT];
  wire logic ignore_clocks_missing_check = clock_check_control[BIT_IGNORE_MISSING];
  wire logic divider_autoset_disable = clock_check_control[BIT_AUTOSET_DISABLE];
  wire logic ignore_pll_lock_check = clock_check_control[BIT_IGNORE_PLL];

  ////////////////////////////////////////////////////////////////////////////
  // format outputs, shared by input and output ports
  wire logic [1:0] sample_word_length = audio_format_length[POS_LENGTH +: 2];
  assign frame_format_select = apc_format_t'(audio_format_length[POS_FORMAT +: 2]);
  assign sample_bits = (sample_word_length == 2'h0) ? 6'h10
                     : (sample_word_length == 2'h1) ? 6'h14
                     : (sample_word_length == 2'h2) ? 6'h18
                     : 6'h20;
  assign sample_bit_offset = audio_data_offset;
  assign left_path_select = channel_path_select[POS_LEFT_PATH +: 2];
  assign right_path_select = channel_path_select[POS_RIGHT_PATH +: 2];

  // manual values only count once autoset is disabled
  assign divider_autoset_active = !divider_autoset_disable;
  assign active_divider = divider_autoset_disable ? manual_divider : auto_divider;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 2 feeds everything, stage 3 only for edges
  logic [3:0] sync_1;
  logic [3:0] sync_2;
  logic [2:0] sync_3;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync_1 <= 4'h0;
      sync_2 <= 4'h0;
      sync_3 <= 3'h0;
    end else begin
      sync_1 <= {pll_locked, mclk_pin, bitclk_pin, frameclk_pin};
      sync_2 <= sync_1;
      sync_3 <= sync_2[2:0];
    end
  end
  wire logic frame_lvl = sync_2[0];
  wire logic bitclk_lvl = sync_2[1];
  wire logic pll_lvl = sync_2[3];
  wire logic frame_rise = sync_2[0] && !sync_3[0];
  wire logic bitclk_rise = sync_2[1] && !sync_3[1];
  wire logic mclk_rise = sync_2[2] && !sync_3[2];

  assign pll_lock_flag = pll_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // per-frame measurements
  logic [11:0] bitclk_count;
  logic bitclk_done;
  logic [MCLK_CNT_W-1:0] mclk_count;
  logic mclk_done;

  apc_frame_counter #(.CNT_W(12)) u_bitclk_count (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .frame_rise(frame_rise),
    .event_rise(bitclk_rise),
    .count(bitclk_count),
    .done(bitclk_done)
  );

  apc_frame_counter #(.CNT_W(MCLK_CNT_W)) u_mclk_count (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .frame_rise(frame_rise),
    .event_rise(mclk_rise),
    .count(mclk_count),
    .done(mclk_done)
  );

  wire logic bitclk_bad = (bitclk_count < BITCLK_RATIO_MIN)
                       || (bitclk_count > BITCLK_RATIO_MAX);

  logic [MCLK_RATIO_COUNT-1:0] ratio_hit;
  for (genvar i = 0; i < MCLK_RATIO_COUNT; i++) begin : g_ratio
    assign ratio_hit[i] = (mclk_count + MCLK_CNT_W'(MCLK_RATIO_TOL) >=
                           MCLK_CNT_W'(MCLK_RATIOS[i]))
                       && (mclk_count <= MCLK_CNT_W'(MCLK_RATIOS[i] + MCLK_RATIO_TOL));
  end
  wire logic mclk_ratio_bad = ~|ratio_hit;

  // frame period in system cycles; a stalled frame clock trips the upper limit
  logic [15:0] frame_cyc;
  wire logic frame_cyc_over = frame_cyc > RATE_MAX_CYC;
  wire logic [15:0] next_frame_cyc = frame_rise ? 16'h0001
                                   : (frame_cyc_over ? frame_cyc : frame_cyc + 16'h0001);
  wire logic rate_bad = (frame_cyc < RATE_MIN_CYC) || frame_cyc_over;

  // master clock halt: static or too slow
  logic [15:0] mclk_idle;
  wire logic mclk_idle_over = mclk_idle > HALT_CYC;
  wire logic [15:0] next_mclk_idle = mclk_rise ? 16'h0000
                                   : (mclk_idle_over ? mclk_idle : mclk_idle + 16'h0001);

  logic rate_fail;
  logic bitclk_fail;
  logic mclk_ratio_fail;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frame_cyc <= 16'h0000;
      mclk_idle <= 16'h0000;
      rate_fail <= 1'b0;
      bitclk_fail <= 1'b0;
      mclk_ratio_fail <= 1'b0;
    end else begin
      frame_cyc <= next_frame_cyc;
      mclk_idle <= next_mclk_idle;
      if (frame_rise) rate_fail <= rate_bad;
      else if (frame_cyc_over) rate_fail <= 1'b1;
      if (bitclk_done) bitclk_fail <= bitclk_bad;
      if (mclk_done) mclk_ratio_fail <= mclk_ratio_bad;
    end
  end

  assign check_status = '{rate_fail: rate_fail, bitclk_fail: bitclk_fail,
                          mclk_ratio_fail: mclk_ratio_fail, mclk_halt: mclk_idle_over,
                          pll_unlock: !pll_lvl};

  ////////////////////////////////////////////////////////////////////////////
  // clock error, registered
  wire logic next_clock_error = (rate_fail && !ignore_rate_check)
                             || (bitclk_fail && !ignore_bitclk_ratio_check)
                             || (mclk_ratio_fail && !ignore_masterclk_ratio_check)
                             || (mclk_idle_over && !ignore_masterclk_halt_check)
                             || (!pll_lvl && !ignore_pll_lock_check);

  ////////////////////////////////////////////////////////////////////////////
  // missing clocks: only both held low counts, not merely static
  logic [31:0] missing_cyc;
  wire logic both_low = !frame_lvl && !bitclk_lvl;
  wire logic [31:0] missing_limit = 32'(missing_clock_period) * 32'(MISSING_STEP_CYCLES)
                                  + 32'(MISSING_STEP_CYCLES);
  wire logic missing = missing_cyc >= missing_limit;
  wire logic [31:0] next_missing_cyc = !both_low ? 32'h0000_0000
                                     : (missing ? missing_cyc : missing_cyc + 32'h0000_0001);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      missing_cyc <= 32'h0000_0000;
      clock_error <= 1'b0;
      converter_powerdown <= 1'b0;
    end else begin
      missing_cyc <= next_missing_cyc;
      clock_error <= next_clock_error;
      converter_powerdown <= missing && !ignore_clocks_missing_check;
    end
  end
endmodule

/* File: verification/apc_clock_check_asserts.sv */
// port-level assertions for the clock check block
`timescale 1ns/1ps
module apc_clock_check_asserts
  import apc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic bitclk_pin,
  input wire logic frameclk_pin,
  input wire apc_divider_t manual_divider,
  input wire apc_divider_t auto_divider,
  input wire apc_divider_t active_divider,
  input wire logic divider_autoset_active,
  input wire logic clock_error,
  input wire logic converter_powerdown,
  input wire apc_check_t check_status,
  input wire apc_format_t frame_format_select,
  input wire logic [5:0] sample_bits,
  input wire logic [7:0] sample_bit_offset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [5:0] len_exp;
  assign len_exp = (reg_wdata[1:0] == 2'h3) ? 6'h20 : 6'h10 + {2'h0, reg_wdata[1:0], 2'h0};
  sequence s_wr(logic [7:0] a);
    reg_write && reg_addr == a;
  endsequence
  property p_div_auto; divider_autoset_active |-> active_divider == auto_divider; endproperty
  a_div_auto: assert property (p_div_auto) else $error("auto divider not used");
  property p_div_man; !divider_autoset_active |-> active_divider == manual_divider; endproperty
  a_div_man: assert property (p_div_man) else $error("manual divider not used");
  property p_autoset;
    s_wr(ADDR_CLOCK_CHECK_CONTROL) |=> divider_autoset_active == !$past(reg_wdata[1]);
  endproperty
  a_autoset: assert property (p_autoset) else $error("autoset flag wrong");
  property p_fmt;
    s_wr(ADDR_AUDIO_FORMAT_LENGTH) |=> frame_format_select == $past(reg_wdata[5:4]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format not taken");
  property p_len; s_wr(ADDR_AUDIO_FORMAT_LENGTH) |=> sample_bits == $past(len_exp); endproperty
  a_len: assert property (p_len) else $error("word length decode wrong");
  property p_ofs; s_wr(ADDR_AUDIO_DATA_OFFSET) |=> sample_bit_offset == $past(reg_wdata); endproperty
  a_ofs: assert property (p_ofs) else $error("offset not taken");
  property p_rsv; reg_addr == ADDR_AUDIO_FORMAT_LENGTH |-> (reg_rdata & 8'hcc) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved format bits set");
  property p_quiet; $past(check_status) == 5'h00 |-> !clock_error; endproperty
  a_quiet: assert property (p_quiet) else $error("clock error without cause");
  property p_pd_low;
    $rose(converter_powerdown) |-> !$past(bitclk_pin, 4) && !$past(frameclk_pin, 4);
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("powerdown with clocks high");
  property p_rst; $rose(rst_b) |-> sample_bits == 6'h18 && !clock_error; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind apc_clock_check apc_clock_check_asserts u_chk (.*);

/* File: verification/apc_audio_source.sv */
// behavioural audio source driving master, bit and frame clocks
`timescale 1ns/1ps
module apc_audio_source (
  input wire logic run,
  input wire logic mclk_on,
  input wire logic pll_ok,
  input wire logic [15:0] bits,
  input wire logic [15:0] bit_half,
  input wire logic [15:0] mclk_half,
  output logic mclk,
  output logic bitclk,
  output logic frameclk,
  output logic pll_locked
);
  assign pll_locked = pll_ok;
  initial begin
    mclk = 1'b0;
    forever begin
      if (mclk_on) begin
        #(mclk_half) mclk = ~mclk;
      end else begin
        mclk = 1'b0;
        #8;
      end
    end
  end
  initial begin
    forever begin
      // a stop ends the frame at the next bit boundary so that missing timing starts promptly
      for (int i = 0; i < bits && run; i++) begin
        frameclk = (i < bits / 2);
        bitclk = 1'b0;
        #(bit_half) bitclk = 1'b1;
        #(bit_half);
      end
      if (!run) begin
        bitclk = 1'b0;
        frameclk = 1'b0;
        #8;
      end
    end
  end
endmodule

/* File: verification/apc_clock_check_bench.sv */
// self-checking bench for the clock check block
`timescale 1ns/1ps
module apc_clock_check_bench;
  import apc_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, reg_write = 1'b0, run = 1'b1, mon = 1'b1, pok = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ofs, v;
  logic [15:0] bits = 16'h0040, bh = 16'h0030, mh = 16'h000c;
  logic mclk, bitclk, frameclk, lock, auto_act, cerr, pd, lock_flag;
  apc_divider_t man = 17'h0a5a5, aut = 17'h15a5a, act;
  apc_check_t st;
  apc_format_t fmt;
  logic [5:0] sbits;
  logic [1:0] lsel, rsel;
  logic [2:0] mcp = 3'h1;
  int err_count = 0, checks_done = 0;
  // entries: good, few bits, bad mclk, fast frame, 256 bits, 32 bits, halt, unlock
  logic [15:0] bits_v [8] = '{16'h40, 16'h10, 16'h40, 16'h40, 16'h100, 16'h20, 16'h40, 16'h40};
  logic [15:0] bh_v [8] = '{16'h30, 16'hc0, 16'h30, 16'h14, 16'h0c, 16'h60, 16'h30, 16'h30};
  logic [15:0] mh_v [8] = '{16'h0c, 16'h0c, 16'h14, 16'h0c, 16'h0c, 16'h0c, 16'h0c, 16'h0c};
  logic [4:0] exp_v [8] = '{5'h00, 5'h08, 5'h04, 5'h14, 5'h00, 5'h00, 5'h06, 5'h01};
  logic [7:0] a_v [4] = '{8'h25, 8'h28, 8'h29, 8'h2a};
  logic [7:0] r_v [4] = '{8'h00, 8'h02, 8'h00, 8'h11};
  logic [7:0] m_v [4] = '{8'h7f, 8'h33, 8'hff, 8'h33};
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  apc_clock_check #(.MISSING_STEP_CYCLES(100)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(addr), .reg_write(reg_write), .reg_wdata(wdata), .reg_rdata(rdata),
    .mclk_pin(mclk), .bitclk_pin(bitclk), .frameclk_pin(frameclk), .pll_locked(lock),
    .missing_clock_period(mcp), .manual_divider(man), .auto_divider(aut),
    .active_divider(act), .divider_autoset_active(auto_act), .clock_error(cerr),
    .converter_powerdown(pd), .pll_lock_flag(lock_flag), .check_status(st),
    .frame_format_select(fmt), .sample_bits(sbits), .sample_bit_offset(ofs),
    .left_path_select(lsel), .right_path_select(rsel));
  apc_audio_source src (.run(run), .mclk_on(mon), .pll_ok(pok), .bits(bits), .bit_half(bh),
    .mclk_half(mh), .mclk(mclk), .bitclk(bitclk), .frameclk(frameclk), .pll_locked(lock));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    @(posedge clk_sys);
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // about 20600 cycles are needed, so this leaves ample margin
    repeat (45000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("sample_bits", sbits, 6'h18);
    chk("left_path_select", lsel, 2'h1);
    chk("right_path_select", rsel, 2'h1);
    for (int i = 0; i < 4; i++) begin
      rd(a_v[i], v);
      chk("reset value", v, r_v[i]);
      wr(a_v[i], 8'hff);
      rd(a_v[i], v);
      chk("write mask", v, m_v[i]);
    end
    wr(8'h26, 8'hff);
    rd(8'h26, v);
    chk("unmapped", v, 8'h00);
    wr(ADDR_CHANNEL_PATH_SELECT, 8'h21);
    cyc(1);
    chk("left_path_select", lsel, 2'h2);
    chk("right_path_select", rsel, 2'h1);
    chk("active_divider", act, man);
    chk("divider_autoset_active", auto_act, 1'b0);
    wr(ADDR_CLOCK_CHECK_CONTROL, 8'h00);
    cyc(1);
    chk("active_divider", act, aut);
    chk("divider_autoset_active", auto_act, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_AUDIO_FORMAT_LENGTH, {2'h0, 2'(i), 2'h0, 2'(i)});
      cyc(1);
      chk("frame_format_select", fmt, i);
      chk("sample_bits", sbits, i == 3 ? 32 : 16 + 4 * i);
    end
    wr(ADDR_AUDIO_DATA_OFFSET, 8'h00);
    cyc(1);
    chk("sample_bit_offset", ofs, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      bits <= bits_v[i];
      bh <= bh_v[i];
      mh <= mh_v[i];
      mon <= (i != 6);
      pok <= (i != 7);
      cyc(2500);
      chk("check_status", st, exp_v[i]);
      chk("clock_error", cerr, |exp_v[i]);
      wr(ADDR_CLOCK_CHECK_CONTROL, {1'b0, exp_v[i][4:1], 2'h0, exp_v[i][0]});
      cyc(6);
      chk("clock_error", cerr, 1'b0);
      chk("pll_lock_flag", lock_flag, i != 7);
      wr(ADDR_CLOCK_CHECK_CONTROL, 8'h00);
    end
    $display("test clock checks done");
    @(posedge clk_sys);
    pok <= 1'b1;
    run <= 1'b0;
    cyc(150);
    chk("converter_powerdown", pd, 1'b0);
    cyc(100);
    chk("converter_powerdown", pd, 1'b1);
    wr(ADDR_CLOCK_CHECK_CONTROL, 8'h04);
    cyc(4);
    chk("converter_powerdown", pd, 1'b0);
    wr(ADDR_CLOCK_CHECK_CONTROL, 8'h00);
    cyc(4);
    chk("converter_powerdown", pd, 1'b1);
    @(posedge clk_sys);
    run <= 1'b1;
    cyc(40);
    chk("converter_powerdown", pd, 1'b0);
    // shortest period: one step of low clocks before powerdown
    @(posedge clk_sys);
    mcp <= 3'h0;
    run <= 1'b0;
    cyc(80);
    chk("converter_powerdown", pd, 1'b0);
    cyc(60);
    chk("converter_powerdown", pd, 1'b1);
    @(posedge clk_sys);
    run <= 1'b1;
    cyc(40);
    chk("converter_powerdown", pd, 1'b0);
    $display("test missing clocks done");
    wrap_up();
  end
endmodule
